/* File: dv/ppcr_tb.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;

   // ****************************************
   // stimulus and design
   // ****************************************
   typedef struct packed {logic we; logic [7:0] addr; logic [31:0] wdata; logic [3:0] be; logic [31:0] exp;} ppcr_row_t;
   // arbitrary identity values
   localparam logic [15:0] DEV = 16'h1B2D;
   localparam logic [15:0] VEN = 16'h4E71;

   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic i_aux_power_sense = 1'b0;
   logic i_cold_wake_enable_cfg = 1'b0;
   logic i_cfg_loaded = 1'b0;
   logic i_cfg_req = 1'b0;
   logic i_cfg_we = 1'b0;
   logic [7:0] i_cfg_addr = 8'h00;
   logic [31:0] i_cfg_wdata = 32'h00000000;
   logic [3:0] i_cfg_be = 4'h0;
   logic o_cfg_ack;
   logic [31:0] o_cfg_rdata;
   logic o_wake_from_cold_off;
   logic o_strap_valid;
   int err_count = 0;
   int check_count = 0;
   logic [31:0] rd;
   logic ak;

   always #5 i_clk_sys = ~i_clk_sys;

   ppcr_top #(.P_DEVICE_CODE(DEV), .P_VENDOR_CODE(VEN)) dut_u (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_aux_power_sense(i_aux_power_sense),
      .i_cold_wake_enable_cfg(i_cold_wake_enable_cfg), .i_cfg_loaded(i_cfg_loaded),
      .i_cfg_req(i_cfg_req), .i_cfg_we(i_cfg_we), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
      .i_cfg_be(i_cfg_be), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
      .o_wake_from_cold_off(o_wake_from_cold_off), .o_strap_valid(o_strap_valid)
   );

   // 1111 warm wake, both states, aux per cold bit, 000, rev 010, no next item, id 01
   localparam ppcr_row_t ROWS [12] = '{
      '{1'b0, 8'h80, 32'h0, 4'h0, {DEV, VEN}},
      '{1'b1, 8'h80, 32'hFFFFFFFF, 4'hF, 32'h0},
      '{1'b0, 8'h80, 32'h0, 4'h0, {DEV, VEN}},
      '{1'b0, 8'hC0, 32'h0, 4'h0, 32'hFFC20001},
      '{1'b1, 8'hC0, 32'h00000000, 4'hF, 32'h0},
      '{1'b0, 8'hC0, 32'h0, 4'h0, 32'hFFC20001},
      '{1'b1, 8'h40, 32'hFFFFFFFF, 4'hF, 32'h0},
      '{1'b0, 8'h40, 32'h0, 4'h0, 32'h0000FF00},
      '{1'b1, 8'h40, 32'h0000A500, 4'hD, 32'h0},
      '{1'b1, 8'h42, 32'h00005A00, 4'h2, 32'h0},
      '{1'b0, 8'h43, 32'h0, 4'h0, 32'h00005A00},
      '{1'b0, 8'h44, 32'h0, 4'h0, 32'h0}
   };

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] pm_exp(input logic cold);
      return {cold, 4'hF, 2'h3, {3{cold}}, 3'h0, 3'h2, 8'h00, 8'h01};
   endfunction

   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // one request cycle; ack and data are taken once the accepting edge has landed
   task automatic access(input logic we, input logic [7:0] addr, input logic [31:0] wd, input logic [3:0] be);
      @(posedge i_clk_sys);
      #1;
      i_cfg_req = 1'b1;
      i_cfg_we = we;
      i_cfg_addr = addr;
      i_cfg_wdata = wd;
      i_cfg_be = be;
      @(posedge i_clk_sys);
      #1;
      i_cfg_req = 1'b0;
      ak = o_cfg_ack;
      rd = o_cfg_rdata;
   endtask

   task automatic do_reset(input logic aux, input logic en, input logic ld);
      @(posedge i_clk_sys);
      #1;
      i_rst = 1'b1;
      i_aux_power_sense = aux;
      i_cold_wake_enable_cfg = en;
      i_cfg_loaded = ld;
      repeat (5) @(posedge i_clk_sys);
      #1;
      cmp_word({29'h0, o_cfg_ack, o_strap_valid, o_wake_from_cold_off}, 32'h0, "flags in reset");
      cmp_word(o_cfg_rdata, 32'h0, "rdata in reset");
      i_rst = 1'b0;
   endtask

   task automatic wait_strap();
      for (int n = 0; n < 20 && o_strap_valid !== 1'b1; n++) begin
         @(posedge i_clk_sys);
         #1;
      end
      cmp_bit(o_strap_valid, 1'b1, "strap valid");
   endtask

   task automatic results();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      $display("ERROR %0t watchdog expired", $time);
      results();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      logic a;
      logic e;
      // rows expect a captured cold wake bit of one
      do_reset(1'b1, 1'b1, 1'b1);
      wait_strap();
      for (int i = 0; i < 12; i++) begin
         access(ROWS[i].we, ROWS[i].addr, ROWS[i].wdata, ROWS[i].be);
         cmp_bit(ak, 1'b1, "row ack");
         cmp_word(rd, ROWS[i].exp, $sformatf("row %0d", i));
      end
      $display("test register rows done");

      for (int c = 0; c < 4; c++) begin
         a = c[1];
         e = c[0];
         do_reset(a, e, 1'b1);
         wait_strap();
         cmp_bit(o_wake_from_cold_off, a & e, "cold wake");
         access(1'b0, 8'hC0, 32'h0, 4'h0);
         cmp_bit(ak, 1'b1, "ack pm read");
         cmp_word(rd, pm_exp(a & e), "pm word");
      end
      $display("test cold wake combinations done");

      // enable not yet loaded: capture must hold off
      do_reset(1'b1, 1'b1, 1'b0);
      repeat (10) @(posedge i_clk_sys);
      #1;
      cmp_bit(o_strap_valid, 1'b0, "strap before load");
      access(1'b0, 8'hC0, 32'h0, 4'h0);
      cmp_word(rd, pm_exp(1'b0), "pm before capture");
      i_cfg_loaded = 1'b1;
      wait_strap();
      cmp_bit(o_wake_from_cold_off, 1'b1, "cold wake after load");
      $display("test capture after load done");

      // back to back: write, read the same place, read identity, write and read the PM word, then idle
      @(posedge i_clk_sys);
      #1;
      i_cfg_req = 1'b1;
      i_cfg_we = 1'b1;
      i_cfg_addr = 8'h40;
      i_cfg_wdata = 32'h00003C00;
      i_cfg_be = 4'h2;
      @(posedge i_clk_sys);
      #1;
      cmp_word({o_cfg_ack, o_cfg_rdata[30:0]}, 32'h80000000, "b2b write");
      i_cfg_we = 1'b0;
      @(posedge i_clk_sys);
      #1;
      cmp_word(o_cfg_rdata, 32'h00003C00, "b2b scratch");
      cmp_bit(o_cfg_ack, 1'b1, "b2b ack");
      i_cfg_addr = 8'h80;
      @(posedge i_clk_sys);
      #1;
      cmp_word(o_cfg_rdata, {DEV, VEN}, "b2b ident");
      i_cfg_we = 1'b1;
      i_cfg_addr = 8'hC0;
      i_cfg_wdata = 32'hFFFFFFFF;
      i_cfg_be = 4'hF;
      @(posedge i_clk_sys);
      #1;
      cmp_word({o_cfg_ack, o_cfg_rdata[30:0]}, 32'h80000000, "b2b pm write");
      i_cfg_we = 1'b0;
      @(posedge i_clk_sys);
      #1;
      cmp_word(o_cfg_rdata, pm_exp(1'b1), "b2b pm read");
      i_cfg_req = 1'b0;
      @(posedge i_clk_sys);
      #1;
      cmp_word({o_cfg_ack, o_cfg_rdata[30:0]}, 32'h0, "idle after b2b");
      $display("test back to back done");

      // only a hard reset clears the scratch byte
      do_reset(1'b0, 1'b0, 1'b1);
      access(1'b0, 8'h40, 32'h0, 4'h0);
      cmp_word(rd, 32'h0, "scratch after reset");
      $display("test scratch reset done");
      results();
   end

endmodule // testbench

`default_nettype wire

/* File: rtl/ppcr_pkg.sv */
package ppcr_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_SCRATCH = 8'h40;
   localparam logic [7:0] OFS_IDENT = 8'h80;
   localparam logic [7:0] OFS_PMCAP = 8'hC0;

   // ****************************************
   // field positions
   // ****************************************
   localparam int SCRATCH_LSB = 8;
   localparam int SCRATCH_MSB = 15;
   localparam int SCRATCH_LANE = 1;
   localparam int PM_COLD_BIT = 31;

   // ****************************************
   // reset and fixed values
   // ****************************************
   localparam logic [7:0] SCRATCH_RST = 8'h00;
   localparam logic [3:0] WAKE_WARM_STATES = 4'hF;
   localparam logic STATE2_SUPPORTED = 1'b1;
   localparam logic STATE1_SUPPORTED = 1'b1;
   localparam logic [2:0] AUX_CURRENT_FULL = 3'h7;
   localparam logic [2:0] AUX_CURRENT_NONE = 3'h0;
   localparam logic DEV_SPECIFIC_INIT = 1'b0;
   localparam logic PM_RSVD20 = 1'b0;
   localparam logic EVENT_CLOCK_DEPENDENCY = 1'b0;
   localparam logic [2:0] SPEC_REVISION = 3'h2;
   localparam logic [7:0] NEXT_ITEM_POINTER = 8'h00;
   localparam logic [7:0] CAPABILITY_CODE = 8'h01;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   // ****************************************
   // timing
   // ****************************************
   localparam int SYNC_STAGES = 2;

endpackage

/* File: rtl/ppcr_strap_if.sv */
`timescale 1ns/10ps
`default_nettype none

// carries the cold-wake decision from the reset sampler to the register bank
interface ppcr_strap_if;
   logic wake_cold;
   logic valid;
   modport src (output wake_cold, output valid);
   modport dst (input wake_cold, input valid);
endinterface

`default_nettype wire

/* File: rtl/ppcr_strap_sampler.sv */
`timescale 1ns/10ps
`default_nettype none

module ppcr_strap_sampler #(
   parameter int P_SYNC_STAGES = ppcr_pkg::SYNC_STAGES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_aux_power_sense,
   input wire logic i_cold_wake_enable_cfg,
   input wire logic i_cfg_loaded,
   ppcr_strap_if.src strap
);

   initial begin
      if (P_SYNC_STAGES < 2) begin
         $error("ppcr_strap_sampler: at least two synchroniser stages are needed");
      end
   end

   typedef enum logic {CAP_WAIT, CAP_DONE} ppcr_cap_t;

   // ****************************************
   // synchroniser for the aux sense pin
   // ****************************************
   logic [P_SYNC_STAGES-1:0] sync_q;
   logic [P_SYNC_STAGES-1:0] sync_d;

   generate
      for (genvar g = 0; g < P_SYNC_STAGES; g++) begin : g_sync
         if (g == 0) begin : g_first
            always_comb sync_d[g] = i_aux_power_sense;
         end else begin : g_next
            always_comb sync_d[g] = sync_q[g-1];
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync_q <= '0;
      end else begin
         sync_q <= sync_d;
      end
   end

   // ****************************************
   // capture once after reset release
   // ****************************************
   // the pipeline must fill before its tail is trusted, hence the settle count
   logic [P_SYNC_STAGES:0] fill_q;
   logic [P_SYNC_STAGES:0] fill_d;
   ppcr_cap_t st_q;
   ppcr_cap_t st_d;
   logic cold_q;
   logic cold_d;
   logic take;

   always_comb begin
      fill_d = {fill_q[P_SYNC_STAGES-1:0], 1'b1};
      st_d = st_q;
      cold_d = cold_q;
      take = fill_q[P_SYNC_STAGES] & i_cfg_loaded;
      unique case (st_q)
         CAP_WAIT: begin
            if (take) begin
               cold_d = sync_q[P_SYNC_STAGES-1] & i_cold_wake_enable_cfg;
               st_d = CAP_DONE;
            end
         end
         CAP_DONE: begin
            st_d = CAP_DONE;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         fill_q <= '0;
         st_q <= CAP_WAIT;
         cold_q <= 1'b0;
      end else begin
         fill_q <= fill_d;
         st_q <= st_d;
         cold_q <= cold_d;
      end
   end

   assign strap.wake_cold = cold_q;
   assign strap.valid = (st_q == CAP_DONE);

   a_cold_pin_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (st_q == CAP_WAIT && take && !sync_q[P_SYNC_STAGES-1]) |=> !cold_q)
      else $error("cold wake set although aux sense was low");

   a_cold_pin_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (st_q == CAP_WAIT && take && sync_q[P_SYNC_STAGES-1] && i_cold_wake_enable_cfg) |=> cold_q)
      else $error("cold wake not set with aux power and enable");

endmodule // ppcr_strap_sampler

`default_nettype wire

/* File: rtl/ppcr_top.sv */
`timescale 1ns/10ps
`default_nettype none

module ppcr_top #(
   // arbitrary identity values, not any real part's codes
   parameter logic [15:0] P_DEVICE_CODE = 16'hA5C3,
   parameter logic [15:0] P_VENDOR_CODE = 16'h3C5A,
   parameter int P_SYNC_STAGES = ppcr_pkg::SYNC_STAGES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_aux_power_sense,
   input wire logic i_cold_wake_enable_cfg,
   input wire logic i_cfg_loaded,
   input wire logic i_cfg_req,
   input wire logic i_cfg_we,
   input wire logic [7:0] i_cfg_addr,
   input wire logic [31:0] i_cfg_wdata,
   input wire logic [3:0] i_cfg_be,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   output logic o_wake_from_cold_off,
   output logic o_strap_valid
);

   initial begin
      if (P_SYNC_STAGES < 2) begin
         $error("ppcr_top: at least two synchroniser stages are needed");
      end
   end

   // ****************************************
   // cold-wake strap capture
   // ****************************************
   ppcr_strap_if strap ();

   ppcr_strap_sampler #(
      .P_SYNC_STAGES(P_SYNC_STAGES)
   ) u_sampler (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_aux_power_sense(i_aux_power_sense),
      .i_cold_wake_enable_cfg(i_cold_wake_enable_cfg),
      .i_cfg_loaded(i_cfg_loaded),
      .strap(strap)
   );

   // ****************************************
   // address decode
   // ****************************************
   // low address bits are ignored: every register is one aligned dword
   logic [5:0] word_idx;
   logic hit_scratch;
   logic hit_ident;
   logic hit_pmcap;
   logic wr_scratch;
   logic rd_cycle;

   always_comb begin
      word_idx = i_cfg_addr[7:2];
      hit_scratch = (word_idx == ppcr_pkg::OFS_SCRATCH[7:2]);
      hit_ident = (word_idx == ppcr_pkg::OFS_IDENT[7:2]);
      hit_pmcap = (word_idx == ppcr_pkg::OFS_PMCAP[7:2]);
      wr_scratch = i_cfg_req & i_cfg_we & hit_scratch & i_cfg_be[ppcr_pkg::SCRATCH_LANE];
      rd_cycle = i_cfg_req & ~i_cfg_we;
   end

   // ****************************************
   // driver scratch byte
   // ****************************************
   // only the hard reset clears it; a driver-level soft reset never reaches this block
   logic [7:0] scratch_q;
   logic [7:0] scratch_d;

   always_comb begin
      scratch_d = scratch_q;
      if (wr_scratch) begin
         scratch_d = i_cfg_wdata[ppcr_pkg::SCRATCH_MSB:ppcr_pkg::SCRATCH_LSB];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         scratch_q <= ppcr_pkg::SCRATCH_RST;
      end else begin
         scratch_q <= scratch_d;
      end
   end

   // ****************************************
   // register images
   // ****************************************
   logic [31:0] img_scratch;
   logic [31:0] img_ident;
   logic [31:0] img_pmcap;
   logic cold_bit;

   always_comb begin
      cold_bit = strap.wake_cold;
      img_scratch = {16'h0000, scratch_q, 8'h00};
      img_ident = {P_DEVICE_CODE, P_VENDOR_CODE};
      img_pmcap = {
         cold_bit,
         ppcr_pkg::WAKE_WARM_STATES,
         ppcr_pkg::STATE2_SUPPORTED,
         ppcr_pkg::STATE1_SUPPORTED,
         (cold_bit ? ppcr_pkg::AUX_CURRENT_FULL : ppcr_pkg::AUX_CURRENT_NONE),
         ppcr_pkg::DEV_SPECIFIC_INIT,
         ppcr_pkg::PM_RSVD20,
         ppcr_pkg::EVENT_CLOCK_DEPENDENCY,
         ppcr_pkg::SPEC_REVISION,
         ppcr_pkg::NEXT_ITEM_POINTER,
         ppcr_pkg::CAPABILITY_CODE
      };
   end

   // ****************************************
   // answer path
   // ****************************************
   // every request is acknowledged the next cycle, writes to read-only words included
   logic ack_q;
   logic ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic cold_out_q;
   logic cold_out_d;
   logic valid_q;
   logic valid_d;

   always_comb begin
      ack_d = i_cfg_req;
      rdata_d = ppcr_pkg::READ_ZERO;
      if (rd_cycle) begin
         if (hit_scratch) begin
            rdata_d = img_scratch;
         end else if (hit_ident) begin
            rdata_d = img_ident;
         end else if (hit_pmcap) begin
            rdata_d = img_pmcap;
         end else begin
            rdata_d = ppcr_pkg::READ_ZERO;
         end
      end
      cold_out_d = strap.wake_cold;
      valid_d = strap.valid;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
         rdata_q <= ppcr_pkg::READ_ZERO;
         cold_out_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         cold_out_q <= cold_out_d;
         valid_q <= valid_d;
      end
   end

   assign o_cfg_ack = ack_q;
   assign o_cfg_rdata = rdata_q;
   assign o_wake_from_cold_off = cold_out_q;
   assign o_strap_valid = valid_q;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   sequence s_pm_write;
      i_cfg_req && i_cfg_we && hit_pmcap;
   endsequence

   sequence s_pm_read;
      i_cfg_req && !i_cfg_we && hit_pmcap;
   endsequence

   sequence s_scratch_write;
      wr_scratch;
   endsequence

   sequence s_scratch_read;
      i_cfg_req && !i_cfg_we && hit_scratch && !wr_scratch;
   endsequence

   a_ack_follows_req: assert property (
      i_cfg_req |=> o_cfg_ack)
      else $error("request not acknowledged next cycle");

   a_no_spurious_ack: assert property (
      !i_cfg_req |=> !o_cfg_ack)
      else $error("acknowledge without request");

   a_ident_read: assert property (
      (rd_cycle && hit_ident) |=> o_cfg_rdata == {P_DEVICE_CODE, P_VENDOR_CODE})
      else $error("identity word wrong");

   a_scratch_roundtrip: assert property (
      s_scratch_write ##1 s_scratch_read |=> o_cfg_rdata[15:8] == $past(i_cfg_wdata[15:8], 2))
      else $error("scratch byte did not hold written value");

   a_scratch_hold: assert property (
      !wr_scratch |=> $stable(scratch_q))
      else $error("scratch byte changed without write");

   a_scratch_rsvd: assert property (
      (rd_cycle && hit_scratch) |=> o_cfg_rdata[31:16] == 16'h0000 && o_cfg_rdata[7:0] == 8'h00)
      else $error("scratch reserved bits not zero");

   a_pm_wake_bits: assert property (
      s_pm_read |=> o_cfg_rdata[30:25] == 6'h3F && o_cfg_rdata[31] == o_wake_from_cold_off)
      else $error("wake or support bits wrong");

   a_aux_current: assert property (
      s_pm_read |=> o_cfg_rdata[24:22] == {3{o_cfg_rdata[31]}})
      else $error("aux current does not follow cold wake bit");

   a_pm_fixed_low: assert property (
      s_pm_write ##1 s_pm_read |=> o_cfg_rdata[21:0] == 22'h020001)
      else $error("fixed capability fields wrong after write");

   a_unmapped_zero: assert property (
      (rd_cycle && !hit_scratch && !hit_ident && !hit_pmcap) |=> o_cfg_rdata == 32'h00000000)
      else $error("unmapped read not zero");

   a_cold_stable: assert property (
      strap.valid |=> $stable(strap.wake_cold) && strap.valid)
      else $error("cold wake bit changed after capture");

   // ****************************************
   // per-field capability word checks
   // ****************************************
   // each fixed field but the two state support bits, which share one check, is guarded on its own so a failure names the broken field

   a_warm_wake: assert property (
      s_pm_read |=> o_cfg_rdata[30:27] == 4'hF)
      else $error("warm state wake bits not all one");

   a_state_support: assert property (
      s_pm_read |=> o_cfg_rdata[26:25] == 2'h3)
      else $error("state support bits not one");

   a_dev_init_zero: assert property (
      s_pm_read |=> o_cfg_rdata[21] == 1'b0)
      else $error("device specific init bit not zero");

   a_pm_rsvd_zero: assert property (
      s_pm_read |=> o_cfg_rdata[20] == 1'b0)
      else $error("reserved capability bit not zero");

   a_event_clock: assert property (
      s_pm_read |=> o_cfg_rdata[19] == 1'b0)
      else $error("event clock dependency bit not zero");

   a_spec_revision: assert property (
      s_pm_read |=> o_cfg_rdata[18:16] == 3'h2)
      else $error("revision field wrong");

   a_next_item: assert property (
      s_pm_read |=> o_cfg_rdata[15:8] == 8'h00)
      else $error("next item pointer not zero");

   a_cap_code: assert property (
      s_pm_read |=> o_cfg_rdata[7:0] == 8'h01)
      else $error("capability code wrong");

   a_aux_none: assert property (
      (rd_cycle && hit_pmcap && !strap.wake_cold) |=> o_cfg_rdata[31] == 1'b0 && o_cfg_rdata[24:22] == 3'h0)
      else $error("aux current or cold bit set without cold wake");

   a_aux_full: assert property (
      (rd_cycle && hit_pmcap && strap.wake_cold) |=> o_cfg_rdata[31] == 1'b1 && o_cfg_rdata[24:22] == 3'h7)
      else $error("aux current not full with cold wake");

   a_scratch_write: assert property (
      s_scratch_write |=> scratch_q == $past(i_cfg_wdata[15:8]))
      else $error("scratch byte did not take written value");

   a_scratch_lane: assert property (
      (i_cfg_req && i_cfg_we && hit_scratch && !i_cfg_be[ppcr_pkg::SCRATCH_LANE]) |=> $stable(scratch_q))
      else $error("scratch byte written without its lane enable");

   a_rdata_idle: assert property (
      !rd_cycle |=> o_cfg_rdata == 32'h00000000)
      else $error("read data not zero after write or idle");

   a_cold_out_copy: assert property (
      1'b1 |=> o_wake_from_cold_off == $past(strap.wake_cold))
      else $error("cold wake output does not follow capture");

   a_valid_out_copy: assert property (
      1'b1 |=> o_strap_valid == $past(strap.valid))
      else $error("strap valid output does not follow capture");

endmodule // ppcr_top

`default_nettype wire
